//--- diag_pkg.sv
// Overview of operation
// - Positions one to five and eleven each run own test.
// - Extended position two fills salt box, pumps.
// - Extended position seven drives concentrate pump.
// - Extended position ten runs wireless module test.
// - Load tests need healthy main to interface link.
// - Load tests need valid configuration, no alarm.
// - Link alarm leaves only interface self test, alarm view.
// - Combo in tests two to ten requests electric test.
// - Combo at alarm view clears stored alarms.
// - Self test walks LEDs; keys light, show, beep.
// - Self test blinks all display icons together.
// - Interface self test runs without any precondition.
// - Wash fill drives lock, wash valve, diverter.
// - Prewash fill drives lock, prewash valve, diverter.
// - Softener fill drives lock, wash and prewash valves.
// - Third valve fill drives lock and third valve.
// - Fill tests show tub water level in millimetres.
// - Fill needs lock, level below overload, five minutes.
// - Display models step tests through a sequence.
// - Only power cycle exits; next start electric test.
package diag_pkg;
  // Test positions on the selector or in the test sequence.
  localparam logic [3:0] POS_UI = 4'h1;
  localparam logic [3:0] POS_WASH = 4'h2;
  localparam logic [3:0] POS_PRE = 4'h3;
  localparam logic [3:0] POS_SOFT = 4'h4;
  localparam logic [3:0] POS_THIRD = 4'h5;
  localparam logic [3:0] POS_CONC = 4'h7;
  localparam logic [3:0] POS_WIFI = 4'hA;
  localparam logic [3:0] POS_ALARM = 4'hB;
  // Sequence position after reset.
  localparam logic [3:0] POS_RST = 4'h1;
  // Clock rate and the timing figures derived from it.
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned FILL_MAX_S = 300;
  localparam longint unsigned FILL_CYC = FILL_MAX_S * CLK_HZ;
  localparam longint unsigned LED_STEP_MS = 500;
  localparam longint unsigned LED_CYC = LED_STEP_MS * (CLK_HZ / 1000);
  // Width of the fill and walk timers.
  localparam int unsigned TMR_W = 40;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OFF = 2'b01,
    ST_RUN = 2'b10
  } state_t;
endpackage

//--- diag_seq.sv
`timescale 1ns/1ps
module diag_seq #(
  parameter int unsigned NKEYS = 8,
  parameter int unsigned LVL_W = 8,
  parameter longint unsigned FILL_CYC_P = diag_pkg::FILL_CYC,
  parameter longint unsigned LED_CYC_P = diag_pkg::LED_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic diag_en,
  input wire logic [3:0] sel_pos,
  input wire logic step_key,
  input wire logic start_key,
  input wire logic combo_key,
  input wire logic [NKEYS-1:0] keys,
  input wire logic link_err,
  input wire logic cfg_alarm,
  input wire logic door_locked,
  input wire logic level_over,
  input wire logic [LVL_W-1:0] level_mm,
  input wire logic has_display,
  input wire logic has_diverter,
  input wire logic has_conc_pump,
  input wire logic has_wifi,
  output logic door_lock_q,
  output logic wash_valve_q,
  output logic prewash_valve_q,
  output logic third_valve_q,
  output logic diverter_q,
  output logic salt_valve_q,
  output logic regen_pump_q,
  output logic conc_pump_q,
  output logic wifi_test_q,
  output logic [NKEYS-1:0] leds_q,
  output logic buzzer_q,
  output logic icons_blink_q,
  output logic [LVL_W-1:0] digits_q,
  output logic [3:0] test_q,
  output logic fill_timeout_q,
  output logic alarm_clear_q,
  output logic etm_next_q
);
  import diag_pkg::*;

  // Parameter values the logic cannot serve are refused.
  if (NKEYS < 2 || NKEYS > 15 || LVL_W < 4) begin : g_chk
    $error("diag_seq: NKEYS must be 2..15 and LVL_W at least 4");
  end
  if (FILL_CYC_P < 2 || FILL_CYC_P >= (64'h1 << TMR_W) ||
    LED_CYC_P < 1 || LED_CYC_P >= (64'h1 << TMR_W)) begin : g_chk_t
    $error("diag_seq: FILL_CYC_P or LED_CYC_P out of timer range");
  end

  localparam int unsigned SW = 16 + LVL_W + NKEYS;
  localparam logic [TMR_W-1:0] FILL_LAST = TMR_W'(FILL_CYC_P - 1);
  localparam logic [TMR_W-1:0] LED_LAST = TMR_W'(LED_CYC_P - 1);

  // All pins but clk and srst pass two flops; only the second stage is read below.
  logic [SW-1:0] s1_q;
  logic [SW-1:0] s2_q;
  always_ff @(posedge clk) begin
    s1_q <= {diag_en, sel_pos, step_key, start_key, combo_key, keys,
      link_err, cfg_alarm, door_locked, level_over, level_mm,
      has_display, has_diverter, has_conc_pump, has_wifi};
    s2_q <= s1_q;
  end

  // Named views of the synchronised pins.
  logic en_s, step_s, start_s, combo_s, lerr_s, cerr_s, door_s, over_s;
  logic disp_s, div_s, conc_s, wifi_s;
  logic [3:0] sel_s;
  logic [NKEYS-1:0] keys_s;
  logic [LVL_W-1:0] lvl_s;
  assign {en_s, sel_s, step_s, start_s, combo_s, keys_s, lerr_s, cerr_s,
    door_s, over_s, lvl_s, disp_s, div_s, conc_s, wifi_s} = s2_q;

  // Previous key levels for edge detection.
  logic step_p_q, start_p_q, combo_p_q;
  logic [3:0] sel_p_q;
  always_ff @(posedge clk) begin
    step_p_q <= step_s;
    start_p_q <= start_s;
    combo_p_q <= combo_s;
    sel_p_q <= sel_s;
  end
  wire step_e = step_s & ~step_p_q;
  wire start_e = start_s & ~start_p_q;
  wire combo_e = combo_s & ~combo_p_q;

  // Key number of the lowest pressed key, counted from one.
  function automatic logic [3:0] key_num(input logic [NKEYS-1:0] k);
    logic [3:0] n;
    n = 4'h0;
    for (int i = NKEYS - 1; i >= 0; i--) begin
      if (k[i]) begin
        n = 4'(i + 1);
      end
    end
    return n;
  endfunction

  // Display models keep a sequence position that the step key advances.
  // A selector move still wins, so both ways of choosing agree.
  logic [3:0] seq_q, seq_d;
  assign seq_d = (sel_s != sel_p_q) ? sel_s :
    !step_e ? seq_q :
    (seq_q >= POS_ALARM) ? POS_UI : 4'(seq_q + 4'h1);
  always_ff @(posedge clk) begin
    if (srst) begin
      seq_q <= POS_RST;
    end else begin
      seq_q <= seq_d;
    end
  end
  wire [3:0] pos_w = disp_s ? seq_q : sel_s;

  // Sequencer: a change of position always passes through ST_OFF, one
  // cycle with every load dropped, so no two tests overlap their valves.
  state_t state_q, state_d;
  logic [3:0] cur_q;
  logic ext_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (en_s) begin
          state_d = ST_OFF;
        end
      end
      ST_OFF: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (pos_w != cur_q) begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  // Only reset, which is a power cycle, leaves the mode once entered.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cur_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cur_q <= (state_q == ST_RUN) ? cur_q : pos_w;
    end
  end

  // Decode of the running test.
  wire run = (state_q == ST_RUN);
  wire is_ui = run && (cur_q == POS_UI);
  wire gate_ok = !lerr_s && !cerr_s;
  wire t_wash = run && gate_ok && (cur_q == POS_WASH) && !ext_q;
  wire t_salt = run && gate_ok && (cur_q == POS_WASH) && ext_q;
  wire t_pre = run && gate_ok && (cur_q == POS_PRE);
  wire t_soft = run && gate_ok && (cur_q == POS_SOFT);
  wire t_third = run && gate_ok && (cur_q == POS_THIRD);
  wire t_conc = run && gate_ok && (cur_q == POS_CONC) && ext_q;
  wire t_wifi = run && gate_ok && (cur_q == POS_WIFI) && ext_q;
  wire t_fill = t_wash || t_salt || t_pre || t_soft || t_third;
  wire ext_ok = (cur_q == POS_WASH) || (cur_q == POS_CONC) ||
    ((cur_q == POS_WIFI) && wifi_s);

  // The start key selects the extended variant of positions 2, 7, 10.
  always_ff @(posedge clk) begin
    if (srst || state_q != ST_RUN) begin
      ext_q <= 1'b0;
    end else if (start_e && ext_ok) begin
      ext_q <= 1'b1;
    end
  end

  // Fill timer runs while a fill test runs; on expiry the valves
  // close and stay closed until a position change or a link or configuration alarm ends the test.
  logic [TMR_W-1:0] fill_cnt_q;
  logic tmo_q;
  always_ff @(posedge clk) begin
    if (srst || !t_fill) begin
      fill_cnt_q <= '0;
      tmo_q <= 1'b0;
    end else if (fill_cnt_q == FILL_LAST) begin
      tmo_q <= 1'b1;
    end else begin
      fill_cnt_q <= fill_cnt_q + TMR_W'(1);
    end
  end
  wire fill_go = door_s && !over_s && !tmo_q;

  // Load selection.
  wire lock_w = t_fill || t_conc;
  wire wash_w = fill_go && (t_wash || t_soft);
  wire pre_w = fill_go && (t_pre || t_soft);
  wire third_w = fill_go && t_third;
  wire div_w = fill_go && div_s && (t_wash || t_pre);
  wire salt_w = fill_go && t_salt;
  wire conc_w = t_conc && conc_s && door_s;
  wire wifi_w = t_wifi && wifi_s;

  // LED walk for the interface self test; also paces the icon blink.
  logic [TMR_W-1:0] walk_cnt_q;
  logic [3:0] walk_q;
  logic blink_q;
  always_ff @(posedge clk) begin
    if (srst || !is_ui) begin
      walk_cnt_q <= '0;
      walk_q <= 4'h0;
      blink_q <= 1'b0;
    end else if (walk_cnt_q >= LED_LAST) begin
      walk_cnt_q <= '0;
      walk_q <= (walk_q >= 4'(NKEYS - 1)) ? 4'h0 : 4'(walk_q + 4'h1);
      blink_q <= ~blink_q;
    end else begin
      walk_cnt_q <= walk_cnt_q + TMR_W'(1);
    end
  end
  wire any_key = |keys_s;
  wire [NKEYS-1:0] walk_led = NKEYS'(1) << walk_q;
  wire [NKEYS-1:0] led_w = !is_ui ? '0 :
    any_key ? keys_s : walk_led;
  wire [LVL_W-1:0] dig_w = is_ui ? LVL_W'(key_num(keys_s)) :
    t_fill ? lvl_s : '0;

  // Output registers; every load is decoded above and only latched here.
  always_ff @(posedge clk) begin
    if (srst) begin
      door_lock_q <= 1'b0;
      wash_valve_q <= 1'b0;
      prewash_valve_q <= 1'b0;
      third_valve_q <= 1'b0;
      diverter_q <= 1'b0;
      salt_valve_q <= 1'b0;
      regen_pump_q <= 1'b0;
      conc_pump_q <= 1'b0;
      wifi_test_q <= 1'b0;
      leds_q <= '0;
      buzzer_q <= 1'b0;
      icons_blink_q <= 1'b0;
      digits_q <= '0;
      test_q <= 4'h0;
      fill_timeout_q <= 1'b0;
    end else begin
      door_lock_q <= lock_w;
      wash_valve_q <= wash_w;
      prewash_valve_q <= pre_w;
      third_valve_q <= third_w;
      diverter_q <= div_w;
      salt_valve_q <= salt_w;
      regen_pump_q <= salt_w;
      conc_pump_q <= conc_w;
      wifi_test_q <= wifi_w;
      leds_q <= led_w;
      buzzer_q <= is_ui && any_key;
      icons_blink_q <= is_ui && disp_s && blink_q;
      digits_q <= dig_w;
      test_q <= run ? cur_q : 4'h0;
      fill_timeout_q <= tmo_q;
    end
  end

  // Key combination actions. The next-start request is also raised on
  // entry, since leaving diagnostics always lands in electric test.
  wire combo_etm = run && combo_e && (cur_q >= POS_WASH) &&
    (cur_q <= POS_WIFI);
  always_ff @(posedge clk) begin
    if (srst) begin
      etm_next_q <= 1'b0;
      alarm_clear_q <= 1'b0;
    end else begin
      etm_next_q <= etm_next_q || combo_etm || run;
      alarm_clear_q <= run && combo_e && (cur_q == POS_ALARM);
    end
  end

  // Checks next to the logic they guard.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire loads_off = !door_lock_q && !wash_valve_q && !prewash_valve_q &&
    !third_valve_q && !salt_valve_q && !conc_pump_q;
  sequence s_swap;
    run && (pos_w != cur_q);
  endsequence
  sequence s_dropped;
    (state_q == ST_OFF) ##1 loads_off;
  endsequence
  AST_SWAP_OFF: assert property (s_swap |=> s_dropped)
    else $error("loads not dropped on position change");
  AST_LINK_ERR: assert property (run && cur_q != POS_UI && lerr_s
    |=> !door_lock_q && !wash_valve_q)
    else $error("load driven with link error");
  AST_CFG_ERR: assert property (run && cerr_s |=> !door_lock_q
    && !prewash_valve_q && !third_valve_q)
    else $error("load driven with configuration alarm");
  AST_SOFT: assert property (run && cur_q == POS_SOFT && gate_ok && fill_go
    |=> door_lock_q && wash_valve_q && prewash_valve_q)
    else $error("softener fill valves wrong");
  AST_THIRD: assert property (third_valve_q |-> door_lock_q
    && !wash_valve_q && !prewash_valve_q)
    else $error("third valve test drives other valves");
  AST_OVER: assert property ((over_s || tmo_q) |=> !wash_valve_q
    && !prewash_valve_q && !third_valve_q)
    else $error("valve open at overload or after timeout");
  AST_ETM: assert property (combo_etm |=> etm_next_q [*2])
    else $error("electric test request not held");
  AST_CLEAR: assert property (run && combo_e && cur_q == POS_ALARM
    |=> alarm_clear_q ##1 !alarm_clear_q)
    else $error("alarm clear not a single pulse");
  AST_UI_FREE: assert property (is_ui && lerr_s && any_key
    |=> buzzer_q && leds_q == $past(keys_s))
    else $error("self test blocked by link error");
endmodule // diag_seq

//--- ui_panel.sv
`timescale 1ns/1ps
module ui_panel #(
  parameter int unsigned NKEYS = 8
) (
  input wire logic clk,
  output logic diag_en,
  output logic [3:0] sel_pos,
  output logic step_key,
  output logic start_key,
  output logic combo_key,
  output logic [NKEYS-1:0] keys
);
  // The panel idles at the first position with no key held.
  initial begin
    diag_en = 1'b0;
    sel_pos = 4'h1;
    step_key = 1'b0;
    start_key = 1'b0;
    combo_key = 1'b0;
    keys = '0;
  end
  // Programme choice and key hold are resolved into one entry level.
  task automatic enter();
    @(negedge clk) diag_en = 1'b1;
  endtask
  // The selector moves only between clock edges, like a real knob.
  task automatic turn(input logic [3:0] p);
    @(negedge clk) sel_pos = p;
  endtask
  // Keys are held six cycles so the synchronisers see every press.
  task automatic tap(input int which, input int k);
    @(negedge clk);
    case (which)
      0: step_key = 1'b1;
      1: start_key = 1'b1;
      2: combo_key = 1'b1;
      default: keys[k] = 1'b1;
    endcase
    repeat (6) @(negedge clk);
    {step_key, start_key, combo_key} = 3'h0;
    keys = '0;
  endtask
endmodule // ui_panel

//--- appliance_diag_test_sequencer_bench.sv
`timescale 1ns/1ps
module appliance_diag_test_sequencer_bench;
  import diag_pkg::*;
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  errors++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
  logic clk, srst, link_err, cfg_alarm, door_locked, level_over;
  logic has_display, has_diverter, has_conc_pump, has_wifi;
  logic [7:0] level_mm, leds_q, digits_q;
  logic diag_en, step_key, start_key, combo_key;
  logic [3:0] sel_pos, test_q;
  logic [7:0] keys;
  logic door_lock_q, wash_valve_q, prewash_valve_q, third_valve_q;
  logic diverter_q, salt_valve_q, regen_pump_q, conc_pump_q, wifi_test_q;
  logic buzzer_q, icons_blink_q, fill_timeout_q, alarm_clear_q, etm_next_q;
  int errors = 0;
  int checks_done = 0;
  // Short timers keep the fill limit and LED walk visible in simulation.
  diag_seq #(.NKEYS(8), .LVL_W(8), .FILL_CYC_P(50), .LED_CYC_P(4)) i_dut (
    .clk(clk), .srst(srst), .diag_en(diag_en), .sel_pos(sel_pos),
    .step_key(step_key), .start_key(start_key), .combo_key(combo_key),
    .keys(keys), .link_err(link_err), .cfg_alarm(cfg_alarm),
    .door_locked(door_locked), .level_over(level_over),
    .level_mm(level_mm), .has_display(has_display),
    .has_diverter(has_diverter), .has_conc_pump(has_conc_pump),
    .has_wifi(has_wifi), .door_lock_q(door_lock_q),
    .wash_valve_q(wash_valve_q), .prewash_valve_q(prewash_valve_q),
    .third_valve_q(third_valve_q), .diverter_q(diverter_q),
    .salt_valve_q(salt_valve_q), .regen_pump_q(regen_pump_q),
    .conc_pump_q(conc_pump_q), .wifi_test_q(wifi_test_q),
    .leds_q(leds_q), .buzzer_q(buzzer_q), .icons_blink_q(icons_blink_q),
    .digits_q(digits_q), .test_q(test_q), .fill_timeout_q(fill_timeout_q),
    .alarm_clear_q(alarm_clear_q), .etm_next_q(etm_next_q));
  ui_panel #(.NKEYS(8)) panel (.clk(clk), .diag_en(diag_en),
    .sel_pos(sel_pos), .step_key(step_key), .start_key(start_key),
    .combo_key(combo_key), .keys(keys));
  // Free-running 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Eight cycles cover the two-flop sync plus the off and load phases.
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  // Each fill position drives its own valve set, with a dark gap between.
  task automatic t_fill();
    logic [4:0] exp [2:5];
    int off;
    exp[2] = 5'h19;
    exp[3] = 5'h15;
    exp[4] = 5'h1C;
    exp[5] = 5'h12;
    for (int p = 2; p <= 5; p++) begin
      panel.turn(4'(p));
      off = 0;
      repeat (10) @(negedge clk) if (!door_lock_q) off++;
      `CHK("gap", 1'b1, off > 0)
      `CHK("loads", exp[p], {door_lock_q, wash_valve_q, prewash_valve_q,
        third_valve_q, diverter_q})
      `CHK("test", 4'(p), test_q)
      `CHK("digits", level_mm, digits_q)
    end
    $display("test fill done");
  endtask
  // Link and configuration faults block loads but not the self test.
  task automatic t_refuse();
    panel.turn(POS_WASH);
    link_err = 1'b1;
    settle();
    `CHK("wash", 1'b0, wash_valve_q)
    panel.turn(POS_UI);
    settle();
    `CHK("test", POS_UI, test_q)
    link_err = 1'b0;
    cfg_alarm = 1'b1;
    panel.turn(POS_PRE);
    settle();
    `CHK("pre", 1'b0, prewash_valve_q)
    cfg_alarm = 1'b0;
    $display("test refuse done");
  endtask
  // The fill limit and the overload level both stop the valves.
  task automatic t_limit();
    panel.turn(POS_SOFT);
    repeat (70) @(negedge clk);
    `CHK("wash", 1'b0, wash_valve_q)
    `CHK("tmo", 1'b1, fill_timeout_q)
    panel.turn(POS_WASH);
    settle();
    level_over = 1'b1;
    settle();
    `CHK("over", 1'b0, wash_valve_q)
    level_over = 1'b0;
    $display("test limit done");
  endtask
  // Start key selects the extended variant at positions 2, 7 and 10.
  task automatic t_ext();
    logic [3:0] pos [3];
    logic [2:0] exp [3];
    pos = '{POS_WASH, POS_CONC, POS_WIFI};
    exp = '{3'h4, 3'h2, 3'h1};
    for (int i = 0; i < 3; i++) begin
      panel.turn(pos[i]);
      settle();
      panel.tap(1, 0);
      settle();
      `CHK("ext", exp[i], {salt_valve_q, conc_pump_q,
        wifi_test_q})
      if (i == 0) `CHK("regen", 1'b1, regen_pump_q)
    end
    $display("test extended done");
  endtask
  // Combination requests electric test mode or clears stored alarms.
  task automatic t_combo();
    int n;
    panel.turn(POS_PRE);
    settle();
    panel.tap(2, 0);
    settle();
    `CHK("etm", 1'b1, etm_next_q)
    panel.turn(POS_ALARM);
    settle();
    n = 0;
    fork
      panel.tap(2, 0);
      repeat (14) @(negedge clk) if (alarm_clear_q) n++;
    join
    `CHK("clear", 1, n)
    $display("test combo done");
  endtask
  // Self test: key lights its LED, shows its number, sounds the buzzer.
  // A link alarm is held throughout, since the self test needs no link.
  task automatic t_ui();
    int tg;
    int nw;
    logic pb;
    logic [7:0] pl;
    link_err = 1'b1;
    panel.turn(POS_UI);
    settle();
    fork
      panel.tap(3, 2);
      begin
        repeat (6) @(negedge clk);
        `CHK("led", 1'b1, leds_q[2])
        `CHK("key", 8'h03, digits_q)
        `CHK("buz", 1'b1, buzzer_q)
      end
    join
    // Count icon toggles and single-LED walk steps over a few periods.
    tg = 0;
    nw = 0;
    pb = icons_blink_q;
    pl = leds_q;
    repeat (24) begin
      @(negedge clk);
      if (icons_blink_q !== pb) tg++;
      if (leds_q !== pl && $countones(leds_q) == 1) nw++;
      pb = icons_blink_q;
      pl = leds_q;
    end
    `CHK("blink", 1'b1, tg > 1)
    `CHK("walk", 1'b1, nw > 1)
    link_err = 1'b0;
    $display("test ui done");
  endtask
  // Power cycle clears the next-start request; then one step key press advances the sequence.
  task automatic t_step();
    srst = 1'b1;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    `CHK("etm0", 1'b0, etm_next_q)
    settle();
    panel.tap(0, 0);
    settle();
    `CHK("step", POS_WASH, test_q)
    `CHK("etm1", 1'b1, etm_next_q)
    $display("test step done");
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs well under two thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    end_of_test();
  end
  // Main sequence: power-on reset, mode entry, then each scenario.
  initial begin
    srst = 1'b1;
    {link_err, cfg_alarm, level_over} = 3'h0;
    {door_locked, has_display, has_diverter} = 3'h7;
    {has_conc_pump, has_wifi} = 2'h3;
    level_mm = 8'h2A;
    repeat (6) @(negedge clk);
    srst = 1'b0;
    panel.enter();
    settle();
    t_fill();
    t_refuse();
    t_limit();
    t_ext();
    t_combo();
    t_ui();
    panel.turn(POS_UI);
    t_step();
    end_of_test();
  end
endmodule // appliance_diag_test_sequencer_bench
